//--- inc/nfi_pkg.sv
// package: register map, field positions and command codes of the interrupt request logic
package nfi_pkg;

    // register port geometry
    localparam int NFI_ADDR_W = 8;
    localparam int NFI_DATA_W = 8;

    // register offsets on the host register port
    localparam logic [7:0] NFI_OFS_FLAGS_LOW = 8'h06;
    localparam logic [7:0] NFI_OFS_FLAGS_HIGH = 8'h07;
    localparam logic [7:0] NFI_OFS_ENABLE_LOW = 8'h08;
    localparam logic [7:0] NFI_OFS_ENABLE_HIGH = 8'h09;

    // reset values
    localparam logic [7:0] NFI_RST_FLAGS_LOW = 8'h00;
    localparam logic [7:0] NFI_RST_ENABLE_LOW = 8'h00;
    localparam logic [7:0] NFI_RST_ENABLE_HIGH = 8'h00;
    localparam logic [7:0] NFI_RD_UNMAPPED = 8'h00;

    // flag bank widths: low bank bits 6..0, high bank bits 5..0 (bit 6 is computed)
    localparam int NFI_LOW_W = 7;
    localparam int NFI_HIGH_W = 6;

    // bit 7 of a flag write chooses set (1) or clear (0)
    localparam int NFI_BIT_SET_MODE = 7;

    // low flag bank positions
    localparam int NFI_BIT_FIFO_HIGH = 6;
    localparam int NFI_BIT_FIFO_LOW = 5;
    localparam int NFI_BIT_CMD_DONE = 4;
    localparam int NFI_BIT_TX_DONE = 3;
    localparam int NFI_BIT_RX_DONE = 2;
    localparam int NFI_BIT_ERROR = 1;
    localparam int NFI_BIT_FRAME_START = 0;

    // high flag bank positions
    localparam int NFI_BIT_SUMMARY = 6;
    localparam int NFI_BIT_CARD_DETECT = 5;
    localparam int NFI_COUNTERS = 5;

    // enable register positions
    localparam int NFI_BIT_PIN_INVERT = 7;
    localparam int NFI_BIT_PIN_STYLE = 7;
    localparam int NFI_BIT_PIN_GATE = 6;

    // number of error sources feeding the error event
    localparam int NFI_FAULTS = 5;

    // command field
    localparam int NFI_CMD_W = 5;
    localparam logic [4:0] NFI_CMD_IDLE = 5'h00;
    // codes that the command engine recognises, one bit per code
    localparam logic [31:0] NFI_CMD_KNOWN = 32'h0000_ffff;

endpackage

//--- inc/nfi_flag_if.sv
// interface: carrier between the register logic and one sticky flag bank
`timescale 1ns/1ps
interface nfi_flag_if #(
    parameter int W = 7
);
    logic wr_stb;
    logic set_mode;
    logic [W-1:0] wr_bits;
    logic [W-1:0] hw_set;
    logic [W-1:0] flags;

    modport owner (
        output wr_stb,
        output set_mode,
        output wr_bits,
        output hw_set,
        input flags
    );

    modport bank (
        input wr_stb,
        input set_mode,
        input wr_bits,
        input hw_set,
        output flags
    );
endinterface

//--- rtl/nfi_flag_bank.sv
// module: sticky event flags with software set or clear and hardware set priority
`timescale 1ns/1ps
module nfi_flag_bank #(
    parameter int W = 7,
    parameter logic [W-1:0] RST = '0
) (
    input logic mclk,
    input logic rst_n,
    nfi_flag_if.bank fif
);
    import nfi_pkg::*;

    typedef struct packed {
        logic [W-1:0] flags;
    } nfi_bank_t;

    nfi_bank_t st_ff;
    nfi_bank_t nxt_st;

    // per bit: zero-written bits keep, ones set or clear, hardware set applied last
    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < W; i++) begin
            if (fif.wr_stb && fif.wr_bits[i]) begin
                nxt_st.flags[i] = fif.set_mode;
            end
            // set wins over a clear in the same cycle so no event is lost
            if (fif.hw_set[i]) begin
                nxt_st.flags[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{flags: RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fif.flags = st_ff.flags;
endmodule

//--- rtl/nfi_irq_logic.sv
// module: interrupt request logic of the reader front end, register port and pin drive
`timescale 1ns/1ps
module nfi_irq_logic (
    input logic mclk,
    input logic resetn,
    // host register port
    input logic [nfi_pkg::NFI_ADDR_W-1:0] reg_addr,
    input logic reg_wr_en,
    input logic [nfi_pkg::NFI_DATA_W-1:0] reg_wdata,
    input logic reg_rd_en,
    output logic [nfi_pkg::NFI_DATA_W-1:0] reg_rdata,
    // command field
    input logic cmd_start,
    input logic [nfi_pkg::NFI_CMD_W-1:0] cmd_start_code,
    input logic cmd_self_end,
    output logic [nfi_pkg::NFI_CMD_W-1:0] command_field,
    // event sources
    input logic fifo_high_level,
    input logic fifo_low_level,
    input logic tx_last_bit_sent,
    input logic rx_stream_end,
    input logic buffer_write_fault,
    input logic buffer_overflow_fault,
    input logic protocol_fault,
    input logic empty_send_fault,
    input logic integrity_fault,
    input logic frame_start_seen,
    input logic subcarrier_seen,
    input logic card_found,
    input logic [nfi_pkg::NFI_COUNTERS-1:0] counter_underflow,
    // interrupt request pin and internal summary
    output logic irq_pin_out,
    output logic irq_pin_oe_n,
    output logic summary_event
);
    import nfi_pkg::*;

    typedef struct packed {
        logic [NFI_DATA_W-1:0] rdata;
        logic [NFI_CMD_W-1:0] cmd_field;
        logic hi_prev;
        logic lo_prev;
        logic [NFI_FAULTS-1:0] fault_prev;
        logic [NFI_DATA_W-1:0] enable_low;
        logic [NFI_DATA_W-1:0] enable_high;
        logic summary;
        logic pin_level;
        logic pin_oe_n;
    } nfi_state_t;

    nfi_state_t st_ff;
    nfi_state_t nxt_st;

    logic [1:0] rst_sync_ff;
    logic rst_n;

    nfi_flag_if #(.W(NFI_LOW_W)) low_if ();
    nfi_flag_if #(.W(NFI_HIGH_W)) high_if ();

    logic [NFI_FAULTS-1:0] faults;
    logic wr_low;
    logic wr_high;
    logic cmd_known;
    logic cmd_done_set;
    logic [NFI_LOW_W-1:0] low_set;
    logic [NFI_HIGH_W-1:0] high_set;
    logic any_low;
    logic any_high;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // the two sticky flag banks
    nfi_flag_bank #(
        .W(NFI_LOW_W),
        .RST(NFI_RST_FLAGS_LOW[NFI_LOW_W-1:0])
    ) u_low_bank (
        .mclk(mclk),
        .rst_n(rst_n),
        .fif(low_if.bank)
    );

    // high bank reset value is our choice; zero keeps the summary and pin quiet
    nfi_flag_bank #(
        .W(NFI_HIGH_W),
        .RST('0)
    ) u_high_bank (
        .mclk(mclk),
        .rst_n(rst_n),
        .fif(high_if.bank)
    );

    // write decode; all event sources share this clock so no synchroniser is needed
    assign wr_low = reg_wr_en && (reg_addr == NFI_OFS_FLAGS_LOW);
    assign wr_high = reg_wr_en && (reg_addr == NFI_OFS_FLAGS_HIGH);

    assign low_if.wr_stb = wr_low;
    assign low_if.set_mode = reg_wdata[NFI_BIT_SET_MODE];
    assign low_if.wr_bits = reg_wdata[NFI_LOW_W-1:0];
    assign low_if.hw_set = low_set;

    // bit 6 of the high register is computed, so only bits 5..0 reach the bank
    assign high_if.wr_stb = wr_high;
    assign high_if.set_mode = reg_wdata[NFI_BIT_SET_MODE];
    assign high_if.wr_bits = reg_wdata[NFI_HIGH_W-1:0];
    assign high_if.hw_set = high_set;

    // fault sources, in one vector for edge detection
    assign faults = {
        buffer_write_fault,
        buffer_overflow_fault,
        protocol_fault,
        empty_send_fault,
        integrity_fault
    };

    // command code lookup against the recognised set
    assign cmd_known = NFI_CMD_KNOWN[cmd_start_code];

    // command done: self termination of a running command, or rejection of an unknown code;
    // a host start of the idle command is excluded on purpose
    always_comb begin
        cmd_done_set = 1'b0;
        if (cmd_start) begin
            if (cmd_start_code == NFI_CMD_IDLE) begin
                cmd_done_set = 1'b0;
            end else if (!cmd_known) begin
                cmd_done_set = 1'b1;
            end
        end else if (cmd_self_end && (st_ff.cmd_field != NFI_CMD_IDLE)) begin
            cmd_done_set = 1'b1;
        end
    end

    // hardware set terms of the low bank
    always_comb begin
        low_set = '0;
        // alert levels are live; only the rising edge latches the sticky copy
        low_set[NFI_BIT_FIFO_HIGH] = fifo_high_level && !st_ff.hi_prev;
        low_set[NFI_BIT_FIFO_LOW] = fifo_low_level && !st_ff.lo_prev;
        low_set[NFI_BIT_CMD_DONE] = cmd_done_set;
        low_set[NFI_BIT_TX_DONE] = tx_last_bit_sent;
        // end of stream only; validity is judged by the fault flags
        low_set[NFI_BIT_RX_DONE] = rx_stream_end;
        low_set[NFI_BIT_ERROR] = |(faults & ~st_ff.fault_prev);
        low_set[NFI_BIT_FRAME_START] = frame_start_seen || subcarrier_seen;
    end

    // hardware set terms of the high bank
    always_comb begin
        high_set = '0;
        high_set[NFI_BIT_CARD_DETECT] = card_found;
        high_set[NFI_COUNTERS-1:0] = counter_underflow;
    end

    // gating of flags into the summary event
    assign any_low = |(low_if.flags & st_ff.enable_low[NFI_LOW_W-1:0]);
    assign any_high = |(high_if.flags & st_ff.enable_high[NFI_HIGH_W-1:0]);

    // next state of everything this module holds
    always_comb begin
        nxt_st = st_ff;

        // edge memories for level sources
        nxt_st.hi_prev = fifo_high_level;
        nxt_st.lo_prev = fifo_low_level;
        nxt_st.fault_prev = faults;

        // command field: a start loads known codes, unknown codes fall back to idle
        if (cmd_start) begin
            if (cmd_known) begin
                nxt_st.cmd_field = cmd_start_code;
            end else begin
                nxt_st.cmd_field = NFI_CMD_IDLE;
            end
        end else if (cmd_self_end) begin
            nxt_st.cmd_field = NFI_CMD_IDLE;
        end

        // enable registers are plain read/write
        if (reg_wr_en && (reg_addr == NFI_OFS_ENABLE_LOW)) begin
            nxt_st.enable_low = reg_wdata;
        end
        if (reg_wr_en && (reg_addr == NFI_OFS_ENABLE_HIGH)) begin
            nxt_st.enable_high = reg_wdata;
        end

        // summary follows the gated flags every cycle; it cannot be written, so a host
        // clear of the source flag or of its enable bit is how the host drops it
        nxt_st.summary = any_low || any_high;

        // pin level: gate, then polarity; inactive level is the inverted zero
        nxt_st.pin_level = (nxt_st.summary && st_ff.enable_high[NFI_BIT_PIN_GATE])
            ^ st_ff.enable_low[NFI_BIT_PIN_INVERT];

        // push-pull drives always; open-drain releases the pin at the high level
        if (st_ff.enable_high[NFI_BIT_PIN_STYLE]) begin
            nxt_st.pin_oe_n = 1'b0;
        end else begin
            nxt_st.pin_oe_n = nxt_st.pin_level;
        end

        // read data, captured on the read strobe; set-mode bits read as zero
        if (reg_rd_en) begin
            unique case (reg_addr)
                NFI_OFS_FLAGS_LOW: begin
                    nxt_st.rdata = {1'b0, low_if.flags};
                end
                NFI_OFS_FLAGS_HIGH: begin
                    nxt_st.rdata = {1'b0, st_ff.summary, high_if.flags};
                end
                NFI_OFS_ENABLE_LOW: begin
                    nxt_st.rdata = st_ff.enable_low;
                end
                NFI_OFS_ENABLE_HIGH: begin
                    nxt_st.rdata = st_ff.enable_high;
                end
                default: begin
                    nxt_st.rdata = NFI_RD_UNMAPPED;
                end
            endcase
        end
    end

    // state register; reset leaves the pin inactive and all gates closed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{
                rdata: NFI_RD_UNMAPPED,
                cmd_field: NFI_CMD_IDLE,
                hi_prev: 1'b0,
                lo_prev: 1'b0,
                fault_prev: '0,
                enable_low: NFI_RST_ENABLE_LOW,
                enable_high: NFI_RST_ENABLE_HIGH,
                summary: 1'b0,
                pin_level: 1'b0,
                pin_oe_n: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign reg_rdata = st_ff.rdata;
    assign command_field = st_ff.cmd_field;
    assign summary_event = st_ff.summary;
    assign irq_pin_out = st_ff.pin_level;
    assign irq_pin_oe_n = st_ff.pin_oe_n;
endmodule

//--- verification/nfi_irq_checker.sv
// checker: port-level assertions of the interrupt request logic
`timescale 1ns/1ps
module nfi_irq_checker (
    input logic mclk,
    input logic resetn,
    input logic [nfi_pkg::NFI_ADDR_W-1:0] reg_addr,
    input logic reg_rd_en,
    input logic [nfi_pkg::NFI_DATA_W-1:0] reg_rdata,
    input logic cmd_start,
    input logic [nfi_pkg::NFI_CMD_W-1:0] cmd_start_code,
    input logic cmd_self_end,
    input logic [nfi_pkg::NFI_CMD_W-1:0] command_field,
    input logic irq_pin_out,
    input logic irq_pin_oe_n,
    input logic summary_event
);
    import nfi_pkg::*;
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);

    unknown_cmd_a: assert property (cmd_start && !NFI_CMD_KNOWN[cmd_start_code]
        |=> command_field == NFI_CMD_IDLE) else $error("unknown code not dropped");
    known_cmd_a: assert property (cmd_start && NFI_CMD_KNOWN[cmd_start_code]
        |=> command_field == $past(cmd_start_code)) else $error("known code not loaded");
    self_end_a: assert property (!cmd_start && cmd_self_end
        |=> command_field == NFI_CMD_IDLE) else $error("self end not idle");
    cmd_hold_a: assert property (!cmd_start && !cmd_self_end
        |=> $stable(command_field)) else $error("command field moved alone");
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without read");
    mode_bit_a: assert property (reg_rd_en && reg_addr inside {8'h06, 8'h07}
        |=> !reg_rdata[7]) else $error("mode bit read back");
    summary_rd_a: assert property (reg_rd_en && reg_addr == NFI_OFS_FLAGS_HIGH
        |=> reg_rdata[6] == $past(summary_event)) else $error("summary bit mismatch");
    // open drain may only release the line for a high level
    drain_level_a: assert property (irq_pin_oe_n |-> irq_pin_out)
        else $error("pin released at low level");
    unmapped_rd_a: assert property (reg_rd_en && reg_addr > NFI_OFS_ENABLE_HIGH
        |=> reg_rdata == NFI_RD_UNMAPPED) else $error("unmapped read not zero");
endmodule

bind nfi_irq_logic nfi_irq_checker i_nfi_irq_checker (
    .mclk(mclk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata),
    .cmd_start(cmd_start),
    .cmd_start_code(cmd_start_code),
    .cmd_self_end(cmd_self_end),
    .command_field(command_field),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n),
    .summary_event(summary_event)
);

//--- verification/nfi_host_model.sv
// host model: register port master for the flag and enable registers
`timescale 1ns/1ps
module nfi_host_model (
    input logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en,
    input logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
    end

    // one write; an idle cycle follows so the strobe never toggles twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
        @(negedge mclk);
    endtask

    // one read; data is taken a cycle late since it holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
endmodule

//--- verification/nfi_irq_logic_bench.sv
// bench: self-checking scenarios for the interrupt request logic
`timescale 1ns/1ps
module nfi_irq_logic_bench;
    import nfi_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_self_end = 1'b0;
    logic [4:0] cmd_start_code = 5'h00;
    logic [16:0] ev_v = 17'h00000;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr_en, reg_rd_en, irq_pin_out, irq_pin_oe_n, summary_event;
    logic [4:0] command_field;
    int bmap [17] = '{0, 0, 2, 3, 5, 6, 1, 1, 1, 1, 1, 5, 0, 1, 2, 3, 4};
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 mclk = ~mclk;

    nfi_irq_logic i_nfi_irq_logic (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata), .cmd_start(cmd_start), .cmd_start_code(cmd_start_code),
        .cmd_self_end(cmd_self_end), .command_field(command_field),
        .fifo_high_level(ev_v[5]), .fifo_low_level(ev_v[4]), .tx_last_bit_sent(ev_v[3]),
        .rx_stream_end(ev_v[2]), .buffer_write_fault(ev_v[6]),
        .buffer_overflow_fault(ev_v[7]), .protocol_fault(ev_v[8]),
        .empty_send_fault(ev_v[9]), .integrity_fault(ev_v[10]),
        .frame_start_seen(ev_v[0]), .subcarrier_seen(ev_v[1]), .card_found(ev_v[11]),
        .counter_underflow(ev_v[16:12]), .irq_pin_out(irq_pin_out),
        .irq_pin_oe_n(irq_pin_oe_n), .summary_event(summary_event));

    nfi_host_model i_nfi_host_model (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata));

    task automatic stop_test();
        $display("checks %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_nfi_host_model.rd(a, d);
        chk(d, exp);
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_nfi_host_model.wr(a, d);
    endtask

    task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        w(a, d);
        rdc(a, exp);
    endtask

    task automatic pin(input logic [7:0] exp);
        cyc(3);
        chk({6'h00, irq_pin_out, irq_pin_oe_n}, exp);
    endtask

    task automatic t_reset();
        rdc(NFI_OFS_FLAGS_LOW, 8'h00);
        rdc(NFI_OFS_ENABLE_HIGH, 8'h00);
        rdc(8'h0a, 8'h00);
        chk({7'h00, irq_pin_out}, 8'h00);
    endtask

    // software set and clear with all enables still off
    task automatic t_soft();
        wrd(8'h06, 8'hff, 8'h7f);
        wrd(8'h06, 8'h05, 8'h7a);
        wrd(8'h06, 8'h7f, 8'h00);
        wrd(8'h07, 8'hff, 8'h3f);
        wrd(8'h07, 8'h3f, 8'h00);
    endtask

    // one pulse per source; level sources drop again so the flag must stick
    task automatic fire(input int i);
        logic [7:0] a;
        logic [7:0] m;
        a = (i > 10) ? 8'h07 : 8'h06;
        m = 8'h01 << bmap[i];
        ev_v[i] = 1'b1;
        cyc(1);
        ev_v[i] = 1'b0;
        cyc(3);
        chk({7'h00, summary_event}, 8'h01);
        rdc(a, (a == 8'h07) ? (m | 8'h40) : m);
        w(a, m);
        cyc(2);
        chk({7'h00, summary_event}, 8'h00);
    endtask

    task automatic t_events();
        w(8'h08, 8'h7f);
        w(8'h09, 8'h3f);
        for (int i = 0; i < 17; i++) begin
            fire(i);
        end
    endtask

    task automatic cmd(input logic [4:0] c, input logic st, input logic [7:0] f, exp);
        cmd_start_code = c;
        cmd_start = st;
        cmd_self_end = !st;
        cyc(1);
        cmd_start = 1'b0;
        cmd_self_end = 1'b0;
        cyc(1);
        chk({3'h0, command_field}, f);
        rdc(8'h06, exp);
        w(8'h06, 8'h7f);
    endtask

    task automatic t_cmd();
        cmd(5'h1f, 1'b1, 8'h00, 8'h10);
        cmd(5'h03, 1'b1, 8'h03, 8'h00);
        // host idle start while a command runs must not raise the done flag
        cmd(5'h00, 1'b1, 8'h00, 8'h00);
        cmd(5'h05, 1'b1, 8'h05, 8'h00);
        cmd(5'h00, 1'b0, 8'h00, 8'h10);
        cmd(5'h00, 1'b0, 8'h00, 8'h00);
    endtask

    // reset in mid-run with flags and enables set; everything must return to zero
    task automatic t_rerun();
        w(8'h06, 8'h81);
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(3);
        rdc(NFI_OFS_FLAGS_LOW, 8'h00);
        rdc(NFI_OFS_ENABLE_LOW, 8'h00);
        chk({7'h00, summary_event}, 8'h00);
    endtask

    // gating, inversion, drive style, and a clear racing a hardware set
    task automatic t_pin();
        w(8'h08, 8'h08);
        w(8'h09, 8'hc0);
        w(8'h06, 8'h84);
        pin(8'h00);
        w(8'h06, 8'h88);
        pin(8'h02);
        w(8'h08, 8'h88);
        pin(8'h00);
        w(8'h09, 8'h40);
        w(8'h08, 8'h08);
        pin(8'h03);
        w(8'h09, 8'h00);
        pin(8'h00);
        ev_v[3] = 1'b1;
        fork
            w(8'h06, 8'h08);
            begin
                cyc(1);
                ev_v[3] = 1'b0;
            end
        join
        rdc(8'h06, 8'h0c);
    endtask

    initial begin
        cyc(5);
        resetn = 1'b1;
        cyc(3);
        t_reset();
        t_soft();
        t_events();
        t_cmd();
        t_pin();
        t_rerun();
        stop_test();
    end
endmodule
